// File: hw/dual_encoder_pkg.sv
package dual_encoder_pkg;

  // Fieldbus parameter addresses
  localparam logic [15:0] ADDR_SOURCE_SELECT   = 16'h0536;
  localparam logic [15:0] ADDR_MAX_DEVIATION   = 16'h053c;
  localparam logic [15:0] ADDR_MOTOR_POSITION  = 16'h1e14;
  localparam logic [15:0] ADDR_DEVIATION       = 16'h1e30;
  localparam logic [15:0] ADDR_EXT_INTERNAL    = 16'h1e32;
  localparam logic [15:0] ADDR_EXT_USER        = 16'h1e34;

  // Reset values and limits
  localparam logic [15:0] SOURCE_SELECT_RESET  = 16'h0000;
  localparam logic [31:0] POSITION_RESET       = 32'h0000_0000;
  localparam logic [31:0] MAX_DEVIATION_RESET  = 32'h0001_0000;
  localparam logic [31:0] MAX_DEVIATION_MIN    = 32'h0000_0001;
  localparam logic [31:0] MAX_DEVIATION_LIMIT  = 32'h0002_0000;
  localparam logic [15:0] WARN_RESET           = 16'h0000;

  // Warning word field
  localparam int          WARN_ABS_POS_BIT     = 13;

  // Control cycle timing
  localparam int          CLK_PERIOD_NS        = 10;
  localparam int          CONTROL_CYCLE_NS     = 1000;
  localparam int          CONTROL_CYCLE_CLKS   =
    (CONTROL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {
    motor_feedback_choice,
    external_feedback_choice
  } feedback_t;

  typedef enum logic {
    home_idle,
    home_busy
  } homing_t;

endpackage

// File: hw/dual_encoder_position_feedback.sv
`timescale 1ns/10ps
module dual_encoder_position_feedback #(
  parameter int CYCLE_CLKS = dual_encoder_pkg::CONTROL_CYCLE_CLKS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Parameter access
  input  wire logic        param_req,
  input  wire logic        param_write,
  input  wire logic [15:0] param_addr,
  input  wire logic [31:0] param_wdata,
  output logic      [31:0] param_rdata,
  output logic             param_ack,
  output logic             param_err,
  // Drive state and encoders
  input  wire logic        drive_disabled,
  input  wire logic        motor_abs_valid,
  input  wire logic [31:0] motor_position,
  input  wire logic [31:0] ext_position_internal,
  input  wire logic [31:0] ext_position_user,
  // Homing
  input  wire logic        homing_start,
  input  wire logic        homing_on_index,
  input  wire logic        homing_done,
  output logic             homing_busy,
  output logic             homing_refused,
  output logic             homing_external,
  output logic             ref_ok,
  output logic      [31:0] reference_position,
  // Regulator feedback and monitoring
  output logic             feedback_external,
  output logic      [31:0] regulator_position,
  output logic             deviation_fault,
  input  wire logic        fault_clear,
  output logic      [15:0] warning_word_latched,
  output logic      [15:0] warning_word_live,
  input  wire logic        warning_clear
);

  typedef struct packed {
    logic [15:0]                    source_select;
    logic [31:0]                    max_deviation;
    logic [31:0]                    motor_pos;
    logic [31:0]                    deviation;
    logic [31:0]                    ext_internal;
    logic [31:0]                    ext_user;
    logic [31:0]                    regulator_pos;
    logic [31:0]                    reference_pos;
    logic [31:0]                    rdata;
    logic                           ack;
    logic                           err;
    logic [15:0]                    warn_latched;
    logic [15:0]                    warn_live;
    logic                           ref_ok;
    dual_encoder_pkg::homing_t      home;
    logic                           homing_ext;
    logic                           homing_refused;
    logic                           dev_fault;
    logic [15:0]                    divider;
    logic                           tick;
  } state_t;

  state_t s;
  state_t next_s;

  localparam logic [15:0] DIV_LAST = 16'(CYCLE_CLKS - 1);

  // Returns {mapped, value} for a parameter read
  function automatic logic [32:0] read_mux(input logic [15:0] a,
                                           input state_t st);
    unique case (a)
      dual_encoder_pkg::ADDR_SOURCE_SELECT:
        read_mux = {1'b1, 16'h0000, st.source_select};
      dual_encoder_pkg::ADDR_MAX_DEVIATION:
        read_mux = {1'b1, st.max_deviation};
      dual_encoder_pkg::ADDR_MOTOR_POSITION:
        read_mux = {1'b1, st.motor_pos};
      dual_encoder_pkg::ADDR_DEVIATION:
        read_mux = {1'b1, st.deviation};
      dual_encoder_pkg::ADDR_EXT_INTERNAL:
        read_mux = {1'b1, st.ext_internal};
      dual_encoder_pkg::ADDR_EXT_USER:
        read_mux = {1'b1, st.ext_user};
      default:
        read_mux = {1'b0, 32'h0000_0000};
    endcase
  endfunction

  logic        ext_active;
  logic [32:0] rd;
  logic        sel_write;
  logic        sel_ok;
  logic        max_write;
  logic        max_ok;
  logic [32:0] diff_wide;
  logic [32:0] diff_abs;
  logic        dev_exceeded;
  logic        home_accept;
  logic        home_finish;

  always_comb begin
    next_s = s;
    ext_active = s.source_select[0];
    rd = read_mux(param_addr, s);
    sel_write = param_req && param_write &&
                param_addr == dual_encoder_pkg::ADDR_SOURCE_SELECT;
    // Only 0 and 1 are legal, and only in the disabled state
    sel_ok = sel_write && drive_disabled && param_wdata[31:1] == 31'h0;
    max_write = param_req && param_write &&
                param_addr == dual_encoder_pkg::ADDR_MAX_DEVIATION;
    max_ok = max_write &&
             $signed(param_wdata) >=
               $signed(dual_encoder_pkg::MAX_DEVIATION_MIN) &&
             $signed(param_wdata) <=
               $signed(dual_encoder_pkg::MAX_DEVIATION_LIMIT);
    // Widened so the most negative difference still has a magnitude
    diff_wide = {s.motor_pos[31], s.motor_pos} -
                {s.ext_internal[31], s.ext_internal};
    diff_abs = diff_wide[32] ? 33'(-diff_wide) : diff_wide;
    dev_exceeded = diff_abs > {1'b0, s.max_deviation};
    home_accept = homing_start && s.home == dual_encoder_pkg::home_idle &&
                  !(ext_active && homing_on_index);
    home_finish = homing_done && s.home == dual_encoder_pkg::home_busy;

    // Parameter port answers every request one cycle later
    next_s.ack = param_req;
    next_s.err = 1'b0;
    next_s.rdata = 32'h0000_0000;
    if (param_req) begin
      if (!param_write) begin
        next_s.rdata = rd[31:0];
        next_s.err = !rd[32];
      end else if (sel_write) begin
        next_s.err = !sel_ok;
      end else if (max_write) begin
        next_s.err = !max_ok;
      end else begin
        // Read-only and unmapped addresses refuse writes
        next_s.err = 1'b1;
      end
    end
    if (sel_ok) begin
      next_s.source_select = param_wdata[15:0];
      if (param_wdata[0] != s.source_select[0]) begin
        next_s.ref_ok = 1'b0;
      end
    end
    if (max_ok) begin
      next_s.max_deviation = param_wdata;
    end

    // Control cycle enable
    next_s.tick = 1'b0;
    if (s.divider == DIV_LAST) begin
      next_s.divider = 16'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.divider = s.divider + 16'h0001;
    end

    // Position sampling on the control cycle
    if (s.tick) begin
      next_s.motor_pos = motor_abs_valid ? motor_position
                       : dual_encoder_pkg::POSITION_RESET;
      next_s.ext_internal = ext_position_internal;
      next_s.ext_user = ext_position_user;
      next_s.deviation = motor_abs_valid ?
        motor_position - ext_position_internal
        : dual_encoder_pkg::POSITION_RESET;
      next_s.regulator_pos = ext_active ? ext_position_internal
                                        : motor_position;
    end

    // Deviation fault, a new excess wins over a clear
    if (fault_clear) begin
      next_s.dev_fault = 1'b0;
    end
    if (s.tick && dev_exceeded) begin
      next_s.dev_fault = 1'b1;
    end

    // Warning bit 13 while absolute position is unknown
    next_s.warn_live[dual_encoder_pkg::WARN_ABS_POS_BIT] =
      !motor_abs_valid;
    if (warning_clear) begin
      next_s.warn_latched = dual_encoder_pkg::WARN_RESET;
    end
    if (!motor_abs_valid) begin
      next_s.warn_latched[dual_encoder_pkg::WARN_ABS_POS_BIT] = 1'b1;
    end

    // Homing
    next_s.homing_refused = homing_start && !home_accept;
    unique case (s.home)
      dual_encoder_pkg::home_idle: begin
        if (home_accept) begin
          next_s.home = dual_encoder_pkg::home_busy;
          next_s.homing_ext = ext_active;
          next_s.ref_ok = 1'b0;
        end
      end
      dual_encoder_pkg::home_busy: begin
        if (home_finish) begin
          next_s.home = dual_encoder_pkg::home_idle;
          next_s.ref_ok = 1'b1;
          next_s.reference_pos = s.homing_ext ? ext_position_internal
                                              : motor_position;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{source_select:  dual_encoder_pkg::SOURCE_SELECT_RESET,
             max_deviation:  dual_encoder_pkg::MAX_DEVIATION_RESET,
             warn_latched:   dual_encoder_pkg::WARN_RESET,
             warn_live:      dual_encoder_pkg::WARN_RESET,
             home:           dual_encoder_pkg::home_idle,
             default:        '0};
    end else begin
      s <= next_s;
    end
  end

  assign param_rdata          = s.rdata;
  assign param_ack            = s.ack;
  assign param_err            = s.err;
  assign homing_busy          = s.home == dual_encoder_pkg::home_busy;
  assign homing_refused       = s.homing_refused;
  assign homing_external      = s.homing_ext;
  assign ref_ok               = s.ref_ok;
  assign reference_position   = s.reference_pos;
  assign feedback_external    = s.source_select[0];
  assign regulator_position   = s.regulator_pos;
  assign deviation_fault      = s.dev_fault;
  assign warning_word_latched = s.warn_latched;
  assign warning_word_live    = s.warn_live;

  sequence seq_sel_write_busy;
    param_req && param_write && !drive_disabled &&
      param_addr == dual_encoder_pkg::ADDR_SOURCE_SELECT;
  endsequence

  sequence seq_sel_write_ok;
    param_req && param_write && drive_disabled &&
      param_addr == dual_encoder_pkg::ADDR_SOURCE_SELECT &&
      param_wdata[31:1] == 31'h0;
  endsequence

  sequence seq_home_begin;
    homing_start && !homing_busy && !(feedback_external && homing_on_index);
  endsequence

  property p_sel_locked;
    @(posedge clk) disable iff (!rstn)
      seq_sel_write_busy |=> param_ack && param_err &&
                             $stable(feedback_external);
  endproperty
  a_sel_locked: assert property (p_sel_locked)
    else $error("source select changed outside disabled state");

  property p_sel_applied;
    @(posedge clk) disable iff (!rstn)
      seq_sel_write_ok |=> !param_err &&
                           feedback_external == $past(param_wdata[0]);
  endproperty
  a_sel_applied: assert property (p_sel_applied)
    else $error("accepted source select not applied next cycle");

  property p_regulator_source;
    @(posedge clk) disable iff (!rstn)
      s.tick |=> regulator_position ==
        ($past(feedback_external) ? $past(ext_position_internal)
                                  : $past(motor_position));
  endproperty
  a_regulator_source: assert property (p_regulator_source)
    else $error("regulator fed from wrong encoder");

  property p_abs_warning;
    @(posedge clk) disable iff (!rstn)
      !motor_abs_valid |=>
        warning_word_live[dual_encoder_pkg::WARN_ABS_POS_BIT] &&
        warning_word_latched[dual_encoder_pkg::WARN_ABS_POS_BIT];
  endproperty
  a_abs_warning: assert property (p_abs_warning)
    else $error("warning bit 13 missing with invalid motor position");

  property p_deviation_value;
    @(posedge clk) disable iff (!rstn)
      s.tick && motor_abs_valid |=>
        s.deviation == $past(motor_position) - $past(ext_position_internal);
  endproperty
  a_deviation_value: assert property (p_deviation_value)
    else $error("deviation is not motor minus external position");

  property p_deviation_fault;
    @(posedge clk) disable iff (!rstn)
      s.tick && dev_exceeded |=>
        deviation_fault ##1 (deviation_fault || $past(fault_clear));
  endproperty
  a_deviation_fault: assert property (p_deviation_fault)
    else $error("deviation excess not flagged");

  property p_index_refused;
    @(posedge clk) disable iff (!rstn)
      homing_start && homing_on_index && feedback_external && !homing_busy
        |=> homing_refused && !homing_busy;
  endproperty
  a_index_refused: assert property (p_index_refused)
    else $error("index homing accepted with external encoder");

  property p_reference_unknown;
    @(posedge clk) disable iff (!rstn)
      seq_home_begin |=> !ref_ok && homing_busy;
  endproperty
  a_reference_unknown: assert property (p_reference_unknown)
    else $error("reference valid while homing run pending");

  property p_home_external;
    @(posedge clk) disable iff (!rstn)
      homing_done && homing_busy && homing_external |=>
        ref_ok && reference_position == $past(ext_position_internal);
  endproperty
  a_home_external: assert property (p_home_external)
    else $error("homing did not use external encoder position");

  property p_read_deviation;
    @(posedge clk) disable iff (!rstn)
      param_req && !param_write &&
        param_addr == dual_encoder_pkg::ADDR_DEVIATION
        |=> param_ack && !param_err && param_rdata == $past(s.deviation);
  endproperty
  a_read_deviation: assert property (p_read_deviation)
    else $error("deviation read returned wrong value");

endmodule

// File: tb/dual_encoder_position_feedback_tb.sv
`timescale 1ns/10ps
module dual_encoder_position_feedback_tb;
  logic clk = 1'b0;
  logic rstn, req, wr_en, dis, absv, hs, hidx, hd, fclr, wclr, ld;
  logic [15:0] addr;
  logic [31:0] wd, rdata, mi, ei, mp, ep, eu, rp, regp, rd, m, e;
  logic ack, err, hb, hr, hx, rok, fext, dfault, er;
  logic [15:0] wl, wa;
  int n_errors, samples_checked, i, seed;

  dual_encoder_position_feedback #(.CYCLE_CLKS(4))
    u_dual_encoder_position_feedback (
    .clk(clk), .rstn(rstn), .param_req(req), .param_write(wr_en),
    .param_addr(addr), .param_wdata(wd), .param_rdata(rdata),
    .param_ack(ack), .param_err(err), .drive_disabled(dis),
    .motor_abs_valid(absv), .motor_position(mp),
    .ext_position_internal(ep), .ext_position_user(eu),
    .homing_start(hs), .homing_on_index(hidx), .homing_done(hd),
    .homing_busy(hb), .homing_refused(hr), .homing_external(hx),
    .ref_ok(rok), .reference_position(rp), .feedback_external(fext),
    .regulator_position(regp), .deviation_fault(dfault),
    .fault_clear(fclr), .warning_word_latched(wl),
    .warning_word_live(wa), .warning_clear(wclr));

  encoder_model u_encoder_model (
    .clk(clk), .rstn(rstn), .load(ld), .motor_in(mi), .ext_in(ei),
    .motor_position(mp), .ext_position_internal(ep),
    .ext_position_user(eu));

  always #5 clk = ~clk;

  function automatic logic [31:0] user_of(input logic [31:0] x);
    return $signed(x) >>> 2;
  endfunction

  task automatic chk32(input string n, input logic [31:0] x,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic chk1(input string n, input logic x, input logic g);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("unexpected %s expected %b seen %b", n, x, g);
    end
  endtask

  // Request held one cycle; answer sampled on the edge after
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    #1;
    req = 1'b1;
    wr_en = w;
    addr = a;
    wd = d;
    @(posedge clk);
    #1;
    req = 1'b0;
    rd = rdata;
    er = err;
    chk1("param_ack", 1'b1, ack);
  endtask

  task automatic rchk(input string n, input logic [15:0] a,
                      input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    chk32(n, x, rd);
    chk1("param_err", 1'b0, er);
  endtask

  task automatic wchk(input string n, input logic [15:0] a,
                      input logic [31:0] d, input logic xe);
    acc(1'b1, a, d);
    chk1(n, xe, er);
  endtask

  task automatic load_pos(input logic [31:0] mv, input logic [31:0] ev);
    @(posedge clk);
    #1;
    ld = 1'b1;
    mi = mv;
    ei = ev;
    @(posedge clk);
    #1;
    ld = 1'b0;
    repeat (12) @(posedge clk);
    #1;
  endtask

  // Strobe k: 0 warning clear, 1 homing start, 2 homing done, 3 fault clear
  // Leading edge keeps back-to-back strobes apart by one low cycle
  task automatic pulse(input int k);
    @(posedge clk);
    #1;
    {fclr, hd, hs, wclr} = 4'h1 << k;
    @(posedge clk);
    #1;
    {fclr, hd, hs, wclr} = 4'h0;
  endtask

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #50000;
    n_errors++;
    tally_and_finish;
  end

  initial begin
    seed = 32'h6e78574f;
    {rstn, req, wr_en, dis, absv, hs, hidx, hd, fclr, wclr, ld} = '0;
    {addr, wd, mi, ei} = '0;
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(posedge clk);
    #1;
    chk1("warn_latched", 1'b1, wl[13]);
    chk1("warn_live", 1'b1, wa[13]);
    rchk("deviation", dual_encoder_pkg::ADDR_DEVIATION, 32'h0);
    rchk("ext_int", dual_encoder_pkg::ADDR_EXT_INTERNAL, 32'h0);
    rchk("ext_usr", dual_encoder_pkg::ADDR_EXT_USER, 32'h0);
    rchk("source", dual_encoder_pkg::ADDR_SOURCE_SELECT, 32'h0);
    load_pos(32'h0000_1234, 32'h0000_0034);
    rchk("motor_inv", dual_encoder_pkg::ADDR_MOTOR_POSITION, 32'h0);
    $display("test reset_values done");

    absv = 1'b1;
    pulse(0);
    @(posedge clk);
    #1;
    chk1("warn_live", 1'b0, wa[13]);
    chk1("warn_latched", 1'b0, wl[13]);
    wchk("src_enabled", dual_encoder_pkg::ADDR_SOURCE_SELECT, 1, 1);
    chk1("fb_ext", 1'b0, fext);
    dis = 1'b1;
    wchk("src_two", dual_encoder_pkg::ADDR_SOURCE_SELECT, 2, 1);
    wchk("src_one", dual_encoder_pkg::ADDR_SOURCE_SELECT, 1, 0);
    chk1("fb_ext", 1'b1, fext);
    // Idle gap standing in for retuning gains on the new feedback
    repeat (4) @(posedge clk);
    wchk("ro_write", dual_encoder_pkg::ADDR_DEVIATION, 5, 1);
    acc(1'b0, 16'h0100, 32'h0);
    chk1("unmapped", 1'b1, er);
    $display("test source_select done");

    for (i = 0; i < 6; i++) begin
      wchk("src", dual_encoder_pkg::ADDR_SOURCE_SELECT, i % 2, 0);
      m = (i == 2) ? 32'sh7fff_ffff : $random(seed) % 30000;
      e = (i == 2) ? 32'sh7fff_ffff : $random(seed) % 30000;
      load_pos(m, e);
      rchk("motor", dual_encoder_pkg::ADDR_MOTOR_POSITION, m);
      rchk("deviation", dual_encoder_pkg::ADDR_DEVIATION, m - e);
      rchk("ext_int", dual_encoder_pkg::ADDR_EXT_INTERNAL, e);
      rchk("ext_usr", dual_encoder_pkg::ADDR_EXT_USER, user_of(e));
      chk32("regulator", (i % 2) ? e : m, regp);
      chk1("fault", 1'b0, dfault);
    end
    $display("test positions done");

    hidx = 1'b1;
    pulse(1);
    chk1("refused", 1'b1, hr);
    chk1("busy", 1'b0, hb);
    hidx = 1'b0;
    pulse(1);
    chk1("busy", 1'b1, hb);
    chk1("ref_ok", 1'b0, rok);
    chk1("home_ext", 1'b1, hx);
    pulse(1);
    chk1("refused_busy", 1'b1, hr);
    pulse(2);
    chk1("busy", 1'b0, hb);
    chk1("ref_ok", 1'b1, rok);
    chk32("ref_pos", e, rp);
    // Motor feedback: index homing allowed, reference from motor
    wchk("src_motor", dual_encoder_pkg::ADDR_SOURCE_SELECT, 0, 0);
    chk1("ref_lost", 1'b0, rok);
    hidx = 1'b1;
    pulse(1);
    chk1("busy_idx", 1'b1, hb);
    chk1("home_mot", 1'b0, hx);
    pulse(2);
    chk32("ref_pos_mot", m, rp);
    hidx = 1'b0;
    $display("test homing done");

    wchk("max_zero", dual_encoder_pkg::ADDR_MAX_DEVIATION, 0, 1);
    wchk("max_over", dual_encoder_pkg::ADDR_MAX_DEVIATION, 131073, 1);
    load_pos(32'h0001_ffff, 32'h0);
    chk1("fault_dflt", 1'b1, dfault);
    wchk("max_top", dual_encoder_pkg::ADDR_MAX_DEVIATION, 131072, 0);
    pulse(3);
    load_pos(32'h0002_0000, 32'h0);
    chk1("fault_at_max", 1'b0, dfault);
    load_pos(32'h0002_0001, 32'h0);
    chk1("fault_over", 1'b1, dfault);
    $display("test deviation_fault done");

    // Mid-run reset must restore defaults and drop the sticky fault
    rstn = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(posedge clk);
    #1;
    chk1("fault_rst", 1'b0, dfault);
    chk1("fb_ext_rst", 1'b0, fext);
    chk1("warn_rst", 1'b0, wl[13]);
    rchk("max_rst", dual_encoder_pkg::ADDR_MAX_DEVIATION,
         dual_encoder_pkg::MAX_DEVIATION_RESET);
    rchk("src_rst", dual_encoder_pkg::ADDR_SOURCE_SELECT, 32'h0);
    $display("test mid_reset done");
    tally_and_finish;
  end
endmodule

// File: tb/encoder_model.sv
`timescale 1ns/10ps
module encoder_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Shaft positions to present
  input  wire logic        load,
  input  wire logic [31:0] motor_in,
  input  wire logic [31:0] ext_in,
  // Encoder outputs
  output logic      [31:0] motor_position,
  output logic      [31:0] ext_position_internal,
  output logic      [31:0] ext_position_user
);
  // Counts hold between loads; user unit is four increments
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      motor_position        <= 32'h0;
      ext_position_internal <= 32'h0;
      ext_position_user     <= 32'h0;
    end else if (load) begin
      motor_position        <= motor_in;
      ext_position_internal <= ext_in;
      ext_position_user     <= $signed(ext_in) >>> 2;
    end
  end
endmodule
